// ==== src/chan_compare_top.v ====
// Timer channel one compare logic with its AHB-Lite register file
//
// Behaviour
// - Frozen mode: matches leave reference unchanged
// - Code 001: reference goes high on match
// - Code 010: reference goes low on match
// - Code 011: reference toggles on each match
// - Codes 100/101 force reference low/high
// - PWM1: high below compare counting up
// - PWM2: inverse levels of PWM mode one
// - Outputs derive from reference through polarity bits
// - Protection level three locks mode, preload bits while direction is output
// - PWM level moves only on compare change or on leaving frozen mode
// - Mode preloaded; commutation loads it when enabled
// - No preload: compare value used immediately
// - Preload: shadow copied on update event
// - Fast off: trigger does not touch output
// - Fast on: trigger acts as match, three cycles
// - Fast path only in PWM modes
// - Direction field picks output or capture source
// - Direction writable only while channel disabled
// - Clear enable: external trigger forces reference low
//
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "chan_cmp_regs.vh"
module chan_compare_top #(
   parameter CNT_W = 16
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // AHB-Lite register bus
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output wire [31:0] hrdata,
   // Timer core signals
   input wire [CNT_W-1:0] counter_value,
   input wire count_down,
   input wire update_event,
   input wire commutation_event,
   input wire trigger_edge,
   input wire filtered_external_trigger,
   // Capture inputs
   input wire timer_input_one,
   input wire timer_input_two,
   input wire internal_trigger_source,
   // Channel outputs
   output wire channel_reference_output,
   output wire channel_true_output,
   output wire channel_complementary_output,
   output wire capture_signal_one
);

   // Fast path pipe depth; the reference flop adds the last cycle
   localparam FAST_DEPTH = `CCM_FAST_LAT - 1;

   // True when the code is one of the two PWM modes
   function is_pwm;
      input [2:0] m;
      begin
         is_pwm = (m == `CCM_PWM1) || (m == `CCM_PWM2);
      end
   endfunction

   // Bus strobes
   wire wr_en; // Write data phase strobe
   wire [7:0] wr_addr; // Write byte address
   wire [31:0] wr_data; // Write data
   wire [7:0] rd_addr; // Read byte address
   reg [31:0] rd_data; // Read mux result
   wire fast_hit; // Delayed trigger edge
   // Mode register fields
   reg [1:0] dir_r; // Channel direction select
   reg fast_r; // Compare fast enable
   reg pe_r; // Compare preload enable
   reg [2:0] mode_pre_r; // Written compare mode
   reg [2:0] mode_act_r; // Mode in use
   reg clr_en_r; // Reference clear enable
   // Compare value
   reg [CNT_W-1:0] ccr_shadow_r; // Software side copy
   reg [CNT_W-1:0] ccr_act_r; // Copy used by comparator
   // Enable and control fields
   reg ce_r; // Channel output enable
   reg cp_r; // True output polarity
   reg cnp_r; // Complementary output polarity
   reg comm_ctl_r; // Commutation preload control
   reg [1:0] lock_r; // Write protection level
   // Output state
   reg ref_r; // Reference output
   reg ref_nxt; // Next reference level
   reg pwm_prev_r; // Last PWM comparison level
   reg [2:0] mode_prev_r; // Mode in use last cycle
   reg true_r; // True channel output
   reg comp_r; // Complementary channel output
   reg cap_r; // Selected capture signal
   // Comparator results
   wire match = (counter_value == ccr_act_r);
   wire below = (counter_value < ccr_act_r);
   wire above = (counter_value > ccr_act_r);
   // PWM mode one level; mode two is its inverse
   wire pwm1_lvl = count_down ? ~above : below;
   wire pwm_lvl = (mode_act_r == `CCM_PWM2) ? ~pwm1_lvl : pwm1_lvl;
   // Write decode
   wire wr_mode = wr_en && (wr_addr == `CCM_OFF_MODE);
   wire wr_cmp = wr_en && (wr_addr == `CCM_OFF_CMP);
   wire wr_ena = wr_en && (wr_addr == `CCM_OFF_ENA);
   wire wr_ctrl = wr_en && (wr_addr == `CCM_OFF_CTRL);
   // Locked when full protection and channel is an output
   wire locked = (lock_r == `CCM_LOCK_FULL) && (dir_r == `CCM_DIR_OUT);
   // Outputs only driven in output direction and when enabled
   wire out_on = ce_r && (dir_r == `CCM_DIR_OUT);

   assign channel_reference_output = ref_r;
   assign channel_true_output = true_r;
   assign channel_complementary_output = comp_r;
   assign capture_signal_one = cap_r;

   // Bus front end
   ahb_reg_slave #(
      .AW(8)
   ) u_bus (
      .clk(clk),
      .rst_n(rst_n),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   // Trigger edge delay for the fast path
   trig_delay #(
      .DEPTH(FAST_DEPTH)
   ) u_fast (
      .clk(clk),
      .rst_n(rst_n),
      .pulse_in(trigger_edge),
      .pulse_out(fast_hit)
   );

   // Mode register writes
   always @(posedge clk) begin
      if (!rst_n) begin
         dir_r <= `CCM_RST_DIR;
         fast_r <= 1'b0;
         pe_r <= 1'b0;
         mode_pre_r <= `CCM_RST_MODE;
         clr_en_r <= 1'b0;
      end else if (wr_mode) begin
         // Direction only while channel is off
         if (!ce_r) begin
            dir_r <= wr_data[`CCM_DIR_LSB+1:`CCM_DIR_LSB];
         end
         // Mode and preload frozen under full protection on an output channel
         if (!locked) begin
            mode_pre_r <= wr_data[`CCM_MODE_LSB+2:`CCM_MODE_LSB];
            pe_r <= wr_data[`CCM_PE_BIT];
         end
         fast_r <= wr_data[`CCM_FAST_BIT];
         clr_en_r <= wr_data[`CCM_CLR_BIT];
      end
   end

   // Active mode: follows preload or waits for commutation
   always @(posedge clk) begin
      if (!rst_n) begin
         mode_act_r <= `CCM_RST_MODE;
      end else if (!comm_ctl_r || commutation_event) begin
         mode_act_r <= mode_pre_r;
      end
   end

   // Compare value, shadow and active copies
   always @(posedge clk) begin
      if (!rst_n) begin
         ccr_shadow_r <= {CNT_W{1'b0}};
         ccr_act_r <= {CNT_W{1'b0}};
      end else begin
         if (wr_cmp) begin
            ccr_shadow_r <= wr_data[CNT_W-1:0];
         end
         // Direct write reaches comparator at once
         if (wr_cmp && !pe_r) begin
            ccr_act_r <= wr_data[CNT_W-1:0];
         end else if (pe_r && update_event) begin
            // Shadow transfer; a same-cycle write lands next update
            ccr_act_r <= ccr_shadow_r;
         end
      end
   end

   // Enable and control registers
   always @(posedge clk) begin
      if (!rst_n) begin
         ce_r <= 1'b0;
         cp_r <= 1'b0;
         cnp_r <= 1'b0;
         comm_ctl_r <= 1'b0;
         lock_r <= `CCM_RST_LOCK;
      end else begin
         if (wr_ena) begin
            ce_r <= wr_data[`CCM_CE_BIT];
            cp_r <= wr_data[`CCM_CP_BIT];
            cnp_r <= wr_data[`CCM_CNP_BIT];
         end
         if (wr_ctrl) begin
            comm_ctl_r <= wr_data[`CCM_COMM_CTL_BIT];
            lock_r <= wr_data[`CCM_LOCK_LSB+1:`CCM_LOCK_LSB];
         end
      end
   end

   // Read mux; unmapped offsets read zero
   always @* begin
      rd_data = 32'h00000000;
      case (rd_addr)
         `CCM_OFF_MODE: begin
            rd_data[`CCM_DIR_LSB+1:`CCM_DIR_LSB] = dir_r;
            rd_data[`CCM_FAST_BIT] = fast_r;
            rd_data[`CCM_PE_BIT] = pe_r;
            rd_data[`CCM_MODE_LSB+2:`CCM_MODE_LSB] = mode_pre_r;
            rd_data[`CCM_CLR_BIT] = clr_en_r;
         end
         `CCM_OFF_CMP: begin
            // Preload on: software sees the shadow
            rd_data[CNT_W-1:0] = pe_r ? ccr_shadow_r : ccr_act_r;
         end
         `CCM_OFF_ENA: begin
            rd_data[`CCM_CE_BIT] = ce_r;
            rd_data[`CCM_CP_BIT] = cp_r;
            rd_data[`CCM_CNP_BIT] = cnp_r;
         end
         `CCM_OFF_CTRL: begin
            rd_data[`CCM_COMM_CTL_BIT] = comm_ctl_r;
            rd_data[`CCM_LOCK_LSB+1:`CCM_LOCK_LSB] = lock_r;
         end
         `CCM_OFF_STAT: begin
            // Live channel state
            rd_data[0] = ref_r;
            rd_data[1] = true_r;
            rd_data[2] = comp_r;
            rd_data[6:4] = mode_act_r;
         end
         default: begin
            rd_data = 32'h00000000;
         end
      endcase
   end

   // Next reference level from mode and comparator
   always @* begin
      ref_nxt = ref_r;
      case (mode_act_r)
         `CCM_FROZEN: begin
            ref_nxt = ref_r;
         end
         `CCM_SET: begin
            if (match) begin
               ref_nxt = 1'b1;
            end
         end
         `CCM_CLEAR: begin
            if (match) begin
               ref_nxt = 1'b0;
            end
         end
         `CCM_TOGGLE: begin
            if (match) begin
               ref_nxt = ~ref_r;
            end
         end
         `CCM_FORCE_LOW: begin
            ref_nxt = 1'b0;
         end
         `CCM_FORCE_HIGH: begin
            ref_nxt = 1'b1;
         end
         `CCM_PWM1, `CCM_PWM2: begin
            // Only a changed comparison or leaving frozen moves it
            if (pwm_lvl != pwm_prev_r || mode_prev_r == `CCM_FROZEN) begin
               ref_nxt = pwm_lvl;
            end
         end
         default: begin
            ref_nxt = ref_r;
         end
      endcase
      // Trigger acts as a match in PWM modes only, at the level reached at
      // compare counting up; without fast enable it goes via the counter
      if (fast_r && fast_hit && is_pwm(mode_act_r)) begin
         ref_nxt = (mode_act_r == `CCM_PWM2);
      end
      // External clear overrides every mode while high
      if (clr_en_r && filtered_external_trigger) begin
         ref_nxt = 1'b0;
      end
   end

   // Reference and comparison history
   always @(posedge clk) begin
      if (!rst_n) begin
         ref_r <= 1'b0;
         pwm_prev_r <= 1'b0;
         mode_prev_r <= `CCM_RST_MODE;
      end else begin
         ref_r <= ref_nxt;
         pwm_prev_r <= pwm_lvl;
         mode_prev_r <= mode_act_r;
      end
   end

   // Polarity stage; registered so outputs move with the reference
   always @(posedge clk) begin
      if (!rst_n) begin
         true_r <= 1'b0;
         comp_r <= 1'b0;
      end else if (out_on) begin
         true_r <= ref_nxt ^ cp_r;
         comp_r <= ~ref_nxt ^ cnp_r;
      end else begin
         // Disabled channel parks both outputs low
         true_r <= 1'b0;
         comp_r <= 1'b0;
      end
   end

   // Capture source selection by direction
   always @(posedge clk) begin
      if (!rst_n) begin
         cap_r <= 1'b0;
      end else begin
         case (dir_r)
            `CCM_DIR_IN1: begin
               cap_r <= timer_input_one;
            end
            `CCM_DIR_IN2: begin
               cap_r <= timer_input_two;
            end
            `CCM_DIR_TRG: begin
               // Needs a trigger input selected in slave mode control
               cap_r <= internal_trigger_source;
            end
            default: begin
               cap_r <= 1'b0;
            end
         endcase
      end
   end

endmodule // chan_compare_top

// ==== pkg/chan_cmp_regs.vh ====
// Register offsets, field positions, reset values and timing counts for the compare channel
`ifndef CHAN_CMP_REGS_VH
`define CHAN_CMP_REGS_VH

// Byte offsets of the word registers
`define CCM_OFF_MODE 8'h00
`define CCM_OFF_CMP 8'h04
`define CCM_OFF_ENA 8'h08
`define CCM_OFF_CTRL 8'h0C
`define CCM_OFF_STAT 8'h10

// Mode register fields
`define CCM_DIR_LSB 0
`define CCM_FAST_BIT 2
`define CCM_PE_BIT 3
`define CCM_MODE_LSB 4
`define CCM_CLR_BIT 7

// Enable register fields
`define CCM_CE_BIT 0
`define CCM_CP_BIT 1
`define CCM_CNP_BIT 3

// Control register fields
`define CCM_COMM_CTL_BIT 0
`define CCM_LOCK_LSB 4

// Reset values
`define CCM_RST_DIR 2'h0
`define CCM_RST_MODE 3'h0
`define CCM_RST_LOCK 2'h0

// Compare mode codes
`define CCM_FROZEN 3'h0
`define CCM_SET 3'h1
`define CCM_CLEAR 3'h2
`define CCM_TOGGLE 3'h3
`define CCM_FORCE_LOW 3'h4
`define CCM_FORCE_HIGH 3'h5
`define CCM_PWM1 3'h6
`define CCM_PWM2 3'h7

// Direction codes
`define CCM_DIR_OUT 2'h0
`define CCM_DIR_IN1 2'h1
`define CCM_DIR_IN2 2'h2
`define CCM_DIR_TRG 2'h3

// Protection level that freezes mode and preload enable on an output channel
`define CCM_LOCK_FULL 2'h3

// Trigger edge to output, fast path, in clock cycles
`define CCM_FAST_LAT 3

`endif

// ==== src/ahb_reg_slave.v ====
// AHB-Lite slave front end turning bus transfers into register strobes
`timescale 1ns/1ps
module ahb_reg_slave #(
   parameter AW = 8
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // AHB-Lite slave side
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // Register file side
   output wire wr_en,
   output wire [AW-1:0] wr_addr,
   output wire [31:0] wr_data,
   output wire [AW-1:0] rd_addr,
   input wire [31:0] rd_data
);

   // Address phase taken: word transfers only, other sizes ignored
   wire accept = hsel & hready & htrans[1] & (hsize == 3'h2);
   reg wr_pend_r; // Write waiting for its data phase
   reg [AW-1:0] wr_addr_r; // Address captured at address phase

   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wr_en = wr_pend_r;
   assign wr_addr = wr_addr_r;
   assign wr_data = hwdata;
   // Read mux is looked up during the address phase
   assign rd_addr = haddr[AW-1:0];

   // Capture write address, register read data
   always @(posedge clk) begin
      if (!rst_n) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= {AW{1'b0}};
         hrdata <= 32'h00000000;
      end else if (hready) begin
         wr_pend_r <= accept & hwrite;
         if (accept & hwrite) begin
            wr_addr_r <= haddr[AW-1:0];
         end
         // Data stands through the data phase
         if (accept & ~hwrite) begin
            hrdata <= rd_data;
         end
      end
   end

endmodule // ahb_reg_slave

// ==== src/trig_delay.v ====
// Pulse delay line of configurable depth for the trigger path
`timescale 1ns/1ps
module trig_delay #(
   parameter DEPTH = 2
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Pulse in and delayed pulse out
   input wire pulse_in,
   output wire pulse_out
);

   reg [DEPTH-1:0] pipe_r; // Shift stages

   assign pulse_out = pipe_r[DEPTH-1];

   // Shift the pulse one stage per clock
   always @(posedge clk) begin
      if (!rst_n) begin
         pipe_r <= {DEPTH{1'b0}};
      end else if (DEPTH > 1) begin
         pipe_r <= {pipe_r[DEPTH-2:0], pulse_in};
      end else begin
         pipe_r <= {DEPTH{pulse_in}};
      end
   end

endmodule // trig_delay

// ==== tb/chan_compare_properties.sv ====
// Port-level assertions for the compare channel
`timescale 1ns/1ps
module chan_compare_props #(
   parameter CNT_W = 16
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Register bus
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   input wire [31:0] hrdata,
   // Channel pins
   input wire filtered_external_trigger,
   input wire timer_input_one,
   input wire timer_input_two,
   input wire internal_trigger_source,
   input wire channel_reference_output,
   input wire channel_true_output,
   input wire channel_complementary_output,
   input wire capture_signal_one
);
   // Mirror of register bits seen on the bus
   reg wen_r, wmd_r, rde_r, unm_r, clr_r;
   reg [3:0] ce_r;
   reg [1:0] dir_r;
   wire tk = hsel && hready && htrans[1] && hsize == 3'h2;
   // Input picked by the mirrored direction field
   wire sel = dir_r == 2'h1 ? timer_input_one : dir_r == 2'h2 ? timer_input_two :
      dir_r == 2'h3 ? internal_trigger_source : 1'b0;
   // Decode writes in their data phase, reads for the next cycle
   always @(posedge clk) begin
      if (!rst_n) begin
         {wen_r, wmd_r, rde_r, unm_r, clr_r} <= 5'h0;
         ce_r <= 4'h0;
         dir_r <= 2'h0;
      end else begin
         wen_r <= tk && hwrite && haddr[7:0] == 8'h08;
         wmd_r <= tk && hwrite && haddr[7:0] == 8'h00;
         rde_r <= tk && !hwrite && haddr[7:0] == 8'h08;
         unm_r <= tk && !hwrite && haddr[7:0] > 8'h10;
         if (wen_r) begin
            ce_r <= hwdata[3:0] & 4'hB;
         end
         if (wmd_r) begin
            clr_r <= hwdata[7];
            // Direction frozen while the channel is on
            if (!ce_r[0]) begin
               dir_r <= hwdata[1:0];
            end
         end
      end
   end
   // Enable bits unchanged over two samples
   sequence s_ena_held;
      ce_r[0] && dir_r == 2'h0 && $stable(ce_r);
   endsequence
   AST_BUS_OKAY: assert property (@(posedge clk) disable iff (!rst_n)
      hreadyout && !hresp) else $error("bus answer not zero-wait OKAY");
   AST_RESET_QUIET: assert property (@(posedge clk) disable iff (!rst_n) $rose(rst_n) |->
      !channel_reference_output && !channel_true_output && !capture_signal_one)
      else $error("outputs not low after reset");
   AST_OFF_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
      !ce_r[0] [*2] |-> !channel_true_output && !channel_complementary_output)
      else $error("disabled channel drives an output");
   AST_POLARITY: assert property (@(posedge clk) disable iff (!rst_n)
      s_ena_held |-> channel_true_output == (channel_reference_output ^ ce_r[1]) &&
      channel_complementary_output == (!channel_reference_output ^ ce_r[3]))
      else $error("output polarity wrong");
   AST_CAPTURE_SEL: assert property (@(posedge clk) disable iff (!rst_n)
      $stable(dir_r) |-> capture_signal_one == $past(sel)) else $error("capture source wrong");
   AST_CLEAR_LOW: assert property (@(posedge clk) disable iff (!rst_n)
      clr_r && filtered_external_trigger |=> !channel_reference_output)
      else $error("reference not cleared");
   AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
      unm_r |-> hrdata == 32'h0) else $error("unmapped read not zero");
   AST_ENA_READ: assert property (@(posedge clk) disable iff (!rst_n)
      rde_r |-> hrdata == {28'h0, $past(ce_r)}) else $error("enable readback wrong");
endmodule // chan_compare_props
bind chan_compare_top chan_compare_props #(.CNT_W(CNT_W)) props_u (.clk(clk), .rst_n(rst_n),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .filtered_external_trigger(filtered_external_trigger), .timer_input_one(timer_input_one),
   .timer_input_two(timer_input_two), .internal_trigger_source(internal_trigger_source),
   .channel_reference_output(channel_reference_output),
   .channel_true_output(channel_true_output), .capture_signal_one(capture_signal_one),
   .channel_complementary_output(channel_complementary_output));

// ==== tb/tb_top.sv ====
// Self-checking bench for the compare channel
`timescale 1ns/1ps
module tb_top;
   // Clock, reset and bus master
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg hsel = 1'b0;
   reg hwrite = 1'b0;
   reg [1:0] htrans = 2'h0;
   reg [31:0] haddr = 32'h0;
   reg [31:0] hwdata = 32'h0;
   wire hreadyout, hresp;
   wire [31:0] hrdata;
   // Timer core side
   reg [15:0] cnt = 16'h0;
   reg dn = 1'b0, upd = 1'b0, comm_evt = 1'b0, trg = 1'b0, etr = 1'b0;
   reg in_a = 1'b0, in_b = 1'b0, in_t = 1'b0;
   wire ref_o, tru_o, cmp_o, cap_o;
   // Bench state
   integer error_cnt = 0, checks = 0, i, k;
   reg [31:0] rnd = 32'h97AB, q;
   reg e = 1'b0;
   reg [2:0] m = 3'h0;
   reg [15:0] cv = 16'h0;
   always #50 clk = ~clk;
   chan_compare_top #(.CNT_W(16)) dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .counter_value(cnt), .count_down(dn), .update_event(upd), .commutation_event(comm_evt),
      .trigger_edge(trg), .filtered_external_trigger(etr), .timer_input_one(in_a),
      .timer_input_two(in_b), .internal_trigger_source(in_t), .channel_reference_output(ref_o),
      .channel_true_output(tru_o), .channel_complementary_output(cmp_o),
      .capture_signal_one(cap_o));
   // Random source
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Next reference level for a mode and counter sample
   function nref(input [2:0] md, input rp, input [15:0] c, input [15:0] p, input d);
      case (md)
         3'h0: nref = rp;
         3'h1: nref = (c == p) ? 1'b1 : rp;
         3'h2: nref = (c == p) ? 1'b0 : rp;
         3'h3: nref = (c == p) ? !rp : rp;
         3'h4: nref = 1'b0;
         3'h5: nref = 1'b1;
         3'h6: nref = d ? !(c > p) : (c < p);
         default: nref = d ? (c > p) : !(c < p);
      endcase
   endfunction
   // Count one compare, report a mismatch
   task chk(input [31:0] g, input [31:0] x);
      begin
         checks = checks + 1;
         if (g !== x) begin
            error_cnt = error_cnt + 1;
            $display("unexpected at %0t: got %h want %h", $time, g, x);
         end
      end
   endtask
   // One word transfer, read data kept in q
   task bus(input w, input [7:0] a, input [31:0] d);
      begin
         hsel <= 1'b1;
         htrans <= 2'h2;
         hwrite <= w;
         haddr <= {24'h0, a};
         @(posedge clk);
         while (hreadyout !== 1'b1) @(posedge clk);
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= d;
         @(posedge clk);
         while (hreadyout !== 1'b1) @(posedge clk);
         q = hrdata;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      bus(1'b1, a, d);
   endtask
   task rc(input [7:0] a, input [31:0] x);
      begin
         bus(1'b0, a, 32'h0);
         chk(q, x);
      end
   endtask
   // New counter sample; the level checked is the one the last sample caused
   task pt(input [15:0] c, input d);
      begin
         cnt <= c;
         dn <= d;
         @(posedge clk);
         chk(ref_o, e);
         e = nref(m, e, c, cv, d);
      end
   endtask
   // Report counts and the verdict
   task end_of_test;
      begin
         $display("checks %0d error_cnt %0d", checks, error_cnt);
         if (error_cnt == 0 && checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   // Watchdog, far beyond the expected run
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt = error_cnt + 1;
      end_of_test;
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (i = 0; i < 6; i = i + 1) rc({i[5:0], 2'h0}, 32'h0);
      wr(8'h14, 32'hFFFFFFFF);
      // Every mode from a random start level and compare value
      for (k = 0; k < 8; k = k + 1) begin
         rnd = lfsr(rnd);
         cv = rnd[15:0];
         e = rnd[16];
         wr(8'h00, {25'h0, 2'h2, e, 4'h0});
         wr(8'h04, {16'h0, cv});
         wr(8'h00, 32'h0);
         wr(8'h00, {24'h0, 1'b0, k[2:0], k[2] & k[1], 3'h0});
         m = 3'h0;
         pt(cv, 1'b0);
         m = k[2:0];
         for (i = 0; i < 12; i = i + 1) begin
            rnd = lfsr(rnd);
            pt(rnd[0] ? cv : (rnd[2] ? cv - 16'h1 : rnd[31:16]), rnd[1]);
         end
         @(posedge clk);
         chk(ref_o, e);
      end
      // Shadow compare moves to active on update only
      wr(8'h00, 32'h60);
      wr(8'h04, 32'h100);
      wr(8'h00, 32'h68);
      wr(8'h04, 32'h200);
      rc(8'h04, 32'h200);
      cnt <= 16'h150;
      dn <= 1'b0;
      repeat (2) @(posedge clk);
      chk(ref_o, 1'b0);
      upd <= 1'b1;
      @(posedge clk);
      upd <= 1'b0;
      repeat (2) @(posedge clk);
      chk(ref_o, 1'b1);
      // Mode held back until the commutation pulse
      wr(8'h0C, 32'h1);
      wr(8'h00, 32'h40);
      rc(8'h10, 32'h61);
      comm_evt <= 1'b1;
      @(posedge clk);
      comm_evt <= 1'b0;
      repeat (2) @(posedge clk);
      chk(ref_o, 1'b0);
      wr(8'h0C, 32'h0);
      // Trigger: fast PWM1, plain PWM1, fast in set mode
      for (i = 0; i < 3; i = i + 1) begin
         wr(8'h00, 32'h50);
         wr(8'h00, i == 0 ? 32'h6C : (i == 1 ? 32'h68 : 32'h14));
         @(posedge clk);
         trg <= 1'b1;
         @(posedge clk);
         trg <= 1'b0;
         repeat (2) @(posedge clk);
         chk(ref_o, 1'b1);
         @(posedge clk);
         chk(ref_o, i != 0);
         repeat (2) @(posedge clk);
         chk(ref_o, i != 0);
      end
      // External trigger clears a forced-high reference
      wr(8'h00, 32'hD0);
      etr <= 1'b1;
      @(posedge clk);
      etr <= 1'b0;
      @(posedge clk);
      chk(ref_o, 1'b0);
      // Polarity combinations at both levels, channel always enabled
      for (i = 0; i < 8; i = i + 1) begin
         wr(8'h00, i[2] ? 32'h50 : 32'h40);
         wr(8'h08, {28'h0, i[1], 1'b0, i[0], 1'b1});
         repeat (2) @(posedge clk);
         chk(tru_o, i[2] ^ i[0]);
         chk(cmp_o, !i[2] ^ i[1]);
      end
      wr(8'h00, 32'h51);
      rc(8'h00, 32'h50);
      wr(8'h08, 32'h0);
      // Capture source for each input direction
      for (k = 1; k < 4; k = k + 1) begin
         wr(8'h00, k);
         for (i = 0; i < 4; i = i + 1) begin
            rnd = lfsr(rnd);
            {in_a, in_b, in_t} <= rnd[2:0];
            repeat (2) @(posedge clk);
            chk(cap_o, k == 1 ? rnd[2] : (k == 2 ? rnd[1] : rnd[0]));
         end
      end
      // Protection level three on an output channel
      wr(8'h00, 32'h50);
      wr(8'h0C, 32'h30);
      wr(8'h00, 32'h48);
      rc(8'h00, 32'h50);
      chk(ref_o, 1'b1);
      // Second reset in mid-run clears the lock
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rc(8'h0C, 32'h0);
      end_of_test;
   end
endmodule // tb_top
